//--- rfsup_pkg.sv
// constants, register map and types for the rf interlock permit supervisor
package rfsup_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_HZ         = 25_000_000;
    localparam int SAMPLE_MS      = 1;
    localparam int MS_CYCLES      = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int HB_TIMEOUT_MS  = 100;
    localparam int REPORT_BASE_MS = 10;
    localparam int HIST_MAX_MS    = 10;
    localparam int NCAV           = 8;

    // ****************************************
    // limits
    // ****************************************
    localparam logic [6:0]  GAIN_MAX_DB = 7'h64;      // 100 dB, 1 dB per lsb
    localparam logic [14:0] GRAD_MAX    = 15'h61a8;   // 25.000 MV/m, 1 kV/m per lsb
    localparam logic [15:0] TUNER_WARN  = 16'hc350;   // 50000 steps
    localparam logic [3:0]  RATE_MIN    = 4'h1;
    localparam logic [3:0]  RATE_MAX    = 4'ha;
    localparam logic [3:0]  HIST_MAX    = 4'ha;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_PERMIT = 8'h04;
    localparam logic [7:0] REG_BYPASS = 8'h08;
    localparam logic [7:0] REG_GAIN   = 8'h0c;
    localparam logic [7:0] REG_GRAD   = 8'h10;
    localparam logic [7:0] REG_REPORT = 8'h14;
    localparam logic [7:0] REG_HIST   = 8'h18;
    localparam logic [7:0] REG_FAULT  = 8'h1c;
    localparam logic [7:0] REG_STATUS = 8'h20;
    localparam logic [7:0] REG_HDATA  = 8'h24;
    localparam logic [7:0] REG_TUNER  = 8'h28;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_RF_ON      = 0;
    localparam int CTL_RF_OFF     = 1;
    localparam int CTL_AMP_LOOP   = 2;
    localparam int CTL_PHS_LOOP   = 3;
    localparam int CTL_TUNE_AUTO  = 4;
    localparam int CTL_MASK_TUNE  = 5;
    localparam int CTL_MASK_HICUR = 6;
    localparam int CTL_MASK_NODRV = 7;
    localparam int BYP_CRYO       = 8;
    localparam int BYP_ZONE       = 9;
    localparam int RPT_ON_CHANGE  = 4;
    localparam int HIST_SEL_LSB   = 4;
    localparam int HIST_UNFREEZE  = 8;
    localparam int FLT_HELIUM     = 0;
    localparam int FLT_FWD_HIGH   = 1;
    localparam int FLT_GRAD_LOW   = 2;
    localparam int FLT_ARC        = 3;
    localparam int FLT_HEAT       = 4;
    localparam int FLT_QUENCH     = 5;
    localparam int FLT_NO_DRIVE   = 6;
    localparam int FLT_HBEAT      = 7;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] RATE_RST = 4'h1;
    localparam logic [3:0] HIST_RST = 4'ha;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_TRIP} run_state_t;
endpackage

//--- rf_interlock_permit_supervisor.sv
// rf interlock and permit supervisor with wishbone register slave
// Functional notes
// RULE_01: losing control network never stops running
// RULE_02: only interlock faults end normal operation
// RULE_03: heartbeat loss ends operation
// RULE_04: ending drops all permits and drive together
// RULE_05: rf on/off and cavity/cryo/zone bypass
// RULE_06: separate amplifier and supply permit commands
// RULE_07: loop gain 0 to 100 dB
// RULE_08: gradient set point 0 to 25.000 MV/m
// RULE_09: amplitude and phase loops open/closed
// RULE_10: automatic or manual tuning mode select
// RULE_11: rack cuts preamp power without permit
// RULE_12: eight supply permits, one per cavity
// RULE_13: drive only while helium permissive present
// RULE_14: report at 1-10 Hz or on change
// RULE_15: freeze history on fault or trigger
// RULE_16: history window 0 to 10 ms
// RULE_17: history sampled every 1 ms
// RULE_18: flag tuner count above 50000 steps
// RULE_19: helium loss while running trips; needed to start
// RULE_20: forward high, gradient low trip; tune maskable
// RULE_21: window heating trips; high-current maskable
// RULE_22: forward power without drive trips; maskable
// RULE_23: hot air gives warning only
// RULE_24: faults latch until software clears them
`timescale 1ns/10ps
module rf_interlock_permit_supervisor import rfsup_pkg::*; #(
    parameter int MS_CYC = MS_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        we_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        heartbeat_i,
    input  wire logic        helium_plant_ok_i,
    input  wire logic [7:0]  fwd_over_i,
    input  wire logic [7:0]  grad_under_i,
    input  wire logic [7:0]  window_arc_i,
    input  wire logic [7:0]  window_heat_i,
    input  wire logic [7:0]  quench_i,
    input  wire logic [7:0]  fwd_present_i,
    input  wire logic        air_hot_i,
    input  wire logic        user_trig_i,
    input  wire logic        tuner_step_i,
    output logic      [7:0]  amp_permit_o,
    output logic      [7:0]  cathode_hv_supply_permit_o,
    output logic      [7:0]  rf_drive_o,
    output logic      [6:0]  loop_gain_db_o,
    output logic      [14:0] grad_set_o,
    output logic             amp_loop_closed_o,
    output logic             phase_loop_closed_o,
    output logic             tune_auto_o,
    output logic             thermal_warn_o,
    output logic             tuner_warn_o,
    output logic             report_o,
    output logic             hist_frozen_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ****************************************
    // declarations
    // ****************************************
    run_state_t  state_ff;
    logic        ack_ff, req, wr, rd, rf_on_cmd, rf_off_cmd;
    logic [31:0] bmask, wval, rdata;
    logic [7:0]  ctrl_ff, fast_shutdown_fault_ff, fault_set, clr_mask, flt_keep, act;
    logic [15:0] permit_ff, ms_cnt_ff, tuner_cnt_ff, hist_mem [16], hist_word;
    logic [9:0]  bypass_ff;
    logic [6:0]  gain_ff, per_cnt_ff;
    logic [14:0] grad_ff;
    logic [3:0]  rate_ff, hist_len_ff, hist_sel_ff, wptr_ff, rd_idx, base_cnt_ff;
    logic        chg_mode_ff, ms_tick, hb_prev_ff, hb_lost, trig_prev_ff, frozen_ff;
    logic [7:0]  hb_ms_ff;
    logic [7:0]  raw_fwd, raw_grad, raw_arc, raw_heat, raw_quench, raw_nodrv;
    logic        gate_perm, hv_on, tick10, freeze_set;
    logic [12:0] snap, last_snap_ff;

    // ****************************************
    // wishbone classic slave
    // ****************************************
    assign req   = cyc_i & stb_i & ~ack_ff;
    assign wr    = req & we_i;
    assign rd    = req & ~we_i;
    assign bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign ack_o = ack_ff;
    assign wval  = (rdata & ~bmask) | (dat_i & bmask);

    always_ff @(posedge clk_i) begin
        if (rst_i) ack_ff <= 1'b0;
        else       ack_ff <= req;
    end

    assign rf_on_cmd  = wr && adr_i == REG_CTRL && sel_i[0] && dat_i[CTL_RF_ON];   // [RULE_05]
    assign rf_off_cmd = wr && adr_i == REG_CTRL && sel_i[0] && dat_i[CTL_RF_OFF];  // [RULE_05]
    assign clr_mask   = (wr && adr_i == REG_FAULT && sel_i[0]) ? dat_i[7:0] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff     <= CTRL_RST;
            permit_ff   <= 16'h0000;
            bypass_ff   <= 10'h000;
            gain_ff     <= 7'h00;
            grad_ff     <= 15'h0000;
            rate_ff     <= RATE_RST;
            chg_mode_ff <= 1'b0;
            hist_len_ff <= HIST_RST;
            hist_sel_ff <= 4'h0;
        end else if (wr) begin
            case (adr_i)
                REG_CTRL:   ctrl_ff <= wval[7:0] & 8'hfc;                                        // [RULE_09] [RULE_10]
                REG_PERMIT: permit_ff <= wval[15:0];                                             // [RULE_06]
                REG_BYPASS: bypass_ff <= wval[9:0];                                              // [RULE_05]
                REG_GAIN:   gain_ff <= (wval > {25'h0, GAIN_MAX_DB}) ? GAIN_MAX_DB : wval[6:0];   // [RULE_07]
                REG_GRAD:   grad_ff <= (wval > {17'h0, GRAD_MAX}) ? GRAD_MAX : wval[14:0];        // [RULE_08]
                REG_REPORT: if (sel_i[0]) begin
                    rate_ff <= (dat_i[3:0] < RATE_MIN) ? RATE_MIN :
                               (dat_i[3:0] > RATE_MAX) ? RATE_MAX : dat_i[3:0];          // [RULE_14]
                    chg_mode_ff <= dat_i[RPT_ON_CHANGE];
                end
                REG_HIST: if (sel_i[0]) begin
                    hist_len_ff <= (dat_i[3:0] > HIST_MAX) ? HIST_MAX : dat_i[3:0];      // [RULE_16]
                    hist_sel_ff <= dat_i[HIST_SEL_LSB +: 4];
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata = 32'h0;
        case (adr_i)
            REG_CTRL:   rdata = {24'h0, ctrl_ff};
            REG_PERMIT: rdata = {16'h0, permit_ff};
            REG_BYPASS: rdata = {22'h0, bypass_ff};
            REG_GAIN:   rdata = {25'h0, gain_ff};
            REG_GRAD:   rdata = {17'h0, grad_ff};
            REG_REPORT: rdata = {27'h0, chg_mode_ff, rate_ff};
            REG_HIST:   rdata = {23'h0, frozen_ff, hist_sel_ff, hist_len_ff};
            REG_FAULT:  rdata = {24'h0, fast_shutdown_fault_ff};
            REG_STATUS: rdata = {25'h0, frozen_ff, tuner_warn_o, thermal_warn_o, hb_lost,
                                 helium_plant_ok_i, state_ff};
            REG_HDATA:  rdata = (hist_sel_ff < hist_len_ff) ? {16'h0, hist_word} : 32'h0;
            REG_TUNER:  rdata = {16'h0, tuner_cnt_ff};
            default:    rdata = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)   dat_o <= 32'h0;
        else if (rd) dat_o <= rdata;
    end

    // ****************************************
    // millisecond tick and heartbeat watchdog
    // ****************************************
    assign ms_tick = ms_cnt_ff == 16'(MS_CYC - 1);

    always_ff @(posedge clk_i) begin
        if (rst_i || ms_tick) ms_cnt_ff <= 16'h0000;
        else                  ms_cnt_ff <= ms_cnt_ff + 16'h0001;
    end

    assign hb_lost = hb_ms_ff >= 8'(HB_TIMEOUT_MS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hb_prev_ff <= 1'b0;
            hb_ms_ff   <= 8'h00;
        end else begin
            hb_prev_ff <= heartbeat_i;
            if (heartbeat_i != hb_prev_ff)  hb_ms_ff <= 8'h00;
            else if (ms_tick && !hb_lost)   hb_ms_ff <= hb_ms_ff + 8'h01;   // [RULE_03]
        end
    end

    // ****************************************
    // per-cavity interlock evaluation
    // ****************************************
    assign act   = ~bypass_ff[7:0] & {8{~(bypass_ff[BYP_CRYO] | bypass_ff[BYP_ZONE])}};   // [RULE_05]
    assign hv_on = |cathode_hv_supply_permit_o;

    for (genvar i = 0; i < NCAV; i++) begin : g_cav
        assign raw_fwd[i]    = fwd_over_i[i] & act[i];
        assign raw_grad[i]   = grad_under_i[i] & act[i];
        assign raw_arc[i]    = window_arc_i[i] & act[i];
        assign raw_heat[i]   = window_heat_i[i] & act[i];
        assign raw_quench[i] = quench_i[i] & act[i];
        assign raw_nodrv[i]  = fwd_present_i[i] & hv_on & ~rf_drive_o[i] & act[i];   // [RULE_22]
    end

    always_comb begin
        fault_set               = 8'h00;
        fault_set[FLT_HELIUM]   = state_ff == ST_RUN && !helium_plant_ok_i;               // [RULE_19]
        fault_set[FLT_FWD_HIGH] = |raw_fwd && !ctrl_ff[CTL_MASK_TUNE];                    // [RULE_20]
        fault_set[FLT_GRAD_LOW] = |raw_grad && !ctrl_ff[CTL_MASK_TUNE];                   // [RULE_20]
        fault_set[FLT_ARC]      = |raw_arc;
        fault_set[FLT_HEAT]     = |raw_heat && !ctrl_ff[CTL_MASK_HICUR];                  // [RULE_21]
        fault_set[FLT_QUENCH]   = |raw_quench;
        fault_set[FLT_NO_DRIVE] = |raw_nodrv && !ctrl_ff[CTL_MASK_NODRV];                 // [RULE_22]
        fault_set[FLT_HBEAT]    = state_ff == ST_RUN && hb_lost;                          // [RULE_03]
    end

    assign flt_keep = fast_shutdown_fault_ff & ~clr_mask;

    always_ff @(posedge clk_i) begin
        if (rst_i) fast_shutdown_fault_ff <= 8'h00;
        else       fast_shutdown_fault_ff <= flt_keep | fault_set;   // [RULE_24]
    end

    // ****************************************
    // run state
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: if (rf_on_cmd && helium_plant_ok_i && !hb_lost &&
                             fast_shutdown_fault_ff == 8'h00 && fault_set == 8'h00)
                    state_ff <= ST_RUN;                                    // [RULE_19]
                ST_RUN: begin
                    if (fast_shutdown_fault_ff != 8'h00) state_ff <= ST_TRIP;   // [RULE_02]
                    else if (rf_off_cmd)                 state_ff <= ST_IDLE;   // [RULE_05]
                end
                ST_TRIP: if (fast_shutdown_fault_ff == 8'h00) state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // permits, drive and settings outputs
    // ****************************************
    // bus silence has no path into the gate below [RULE_01]
    assign gate_perm = state_ff != ST_TRIP && fast_shutdown_fault_ff == 8'h00 && !hb_lost;   // [RULE_04]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            amp_permit_o               <= 8'h00;
            cathode_hv_supply_permit_o <= 8'h00;
            rf_drive_o                 <= 8'h00;
        end else begin
            amp_permit_o               <= permit_ff[7:0] & act & {8{gate_perm}};    // [RULE_06] [RULE_11]
            cathode_hv_supply_permit_o <= permit_ff[15:8] & act & {8{gate_perm}};   // [RULE_12]
            rf_drive_o <= act & {8{gate_perm && state_ff == ST_RUN && helium_plant_ok_i}};   // [RULE_13]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            loop_gain_db_o      <= 7'h00;
            grad_set_o          <= 15'h0000;
            amp_loop_closed_o   <= 1'b0;
            phase_loop_closed_o <= 1'b0;
            tune_auto_o         <= 1'b0;
            thermal_warn_o      <= 1'b0;
        end else begin
            loop_gain_db_o      <= gain_ff;
            grad_set_o          <= grad_ff;
            amp_loop_closed_o   <= ctrl_ff[CTL_AMP_LOOP];    // [RULE_09]
            phase_loop_closed_o <= ctrl_ff[CTL_PHS_LOOP];    // [RULE_09]
            tune_auto_o         <= ctrl_ff[CTL_TUNE_AUTO];   // [RULE_10]
            thermal_warn_o      <= air_hot_i;                // [RULE_23]
        end
    end

    // ****************************************
    // fault history capture
    // ****************************************
    assign freeze_set = (fault_set & ~fast_shutdown_fault_ff) != 8'h00 || (user_trig_i && !trig_prev_ff);
    assign rd_idx     = wptr_ff - 4'h1 - hist_sel_ff;
    assign hist_word  = hist_mem[rd_idx];
    assign hist_frozen_o = frozen_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev_ff <= 1'b0;
            frozen_ff    <= 1'b0;
        end else begin
            trig_prev_ff <= user_trig_i;
            if (freeze_set) frozen_ff <= 1'b1;   // [RULE_15]
            else if (wr && adr_i == REG_HIST && sel_i[1] && dat_i[HIST_UNFREEZE]) frozen_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)                      wptr_ff <= 4'h0;
        else if (ms_tick && !frozen_ff) wptr_ff <= wptr_ff + 4'h1;   // [RULE_17]
    end

    always_ff @(posedge clk_i) begin
        if (ms_tick && !frozen_ff) hist_mem[wptr_ff] <= {fast_shutdown_fault_ff, rf_drive_o};   // [RULE_17]
    end

    // ****************************************
    // tuner step counter
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || (wr && adr_i == REG_TUNER))     tuner_cnt_ff <= 16'h0000;
        else if (tuner_step_i && tuner_cnt_ff != 16'hffff) tuner_cnt_ff <= tuner_cnt_ff + 16'h0001;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) tuner_warn_o <= 1'b0;
        else       tuner_warn_o <= tuner_cnt_ff > TUNER_WARN;   // [RULE_18]
    end

    // ****************************************
    // reporting to cryogenic systems
    // ****************************************
    function automatic logic [6:0] rate_period(input logic [3:0] r);
        case (r)
            4'h1:    rate_period = 7'h64;
            4'h2:    rate_period = 7'h32;
            4'h3:    rate_period = 7'h22;
            4'h4:    rate_period = 7'h19;
            4'h5:    rate_period = 7'h14;
            4'h6:    rate_period = 7'h11;
            4'h7:    rate_period = 7'h0f;
            4'h8:    rate_period = 7'h0d;
            4'h9:    rate_period = 7'h0c;
            default: rate_period = 7'h0a;
        endcase
    endfunction

    assign tick10 = ms_tick && base_cnt_ff == 4'(REPORT_BASE_MS - 1);
    assign snap   = {state_ff, fast_shutdown_fault_ff, tuner_warn_o, thermal_warn_o, frozen_ff};

    always_ff @(posedge clk_i) begin
        if (rst_i || tick10) base_cnt_ff <= 4'h0;
        else if (ms_tick)    base_cnt_ff <= base_cnt_ff + 4'h1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_cnt_ff   <= 7'h00;
            report_o     <= 1'b0;
            last_snap_ff <= 13'h0000;
        end else begin
            report_o <= 1'b0;
            if (chg_mode_ff) begin
                per_cnt_ff <= 7'h00;
                if (snap != last_snap_ff) begin
                    report_o     <= 1'b1;   // [RULE_14]
                    last_snap_ff <= snap;
                end
            end else if (tick10) begin
                if (per_cnt_ff >= rate_period(rate_ff) - 7'h01) begin
                    per_cnt_ff <= 7'h00;
                    report_o   <= 1'b1;     // [RULE_14]
                end else begin
                    per_cnt_ff <= per_cnt_ff + 7'h01;
                end
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_trig_edge;
        !user_trig_i ##1 user_trig_i;
    endsequence
    sequence s_all_off;
        amp_permit_o == 8'h00 && cathode_hv_supply_permit_o == 8'h00 && rf_drive_o == 8'h00;
    endsequence

    a_comm_loss_run: assert property ((state_ff == ST_RUN && !cyc_i && fault_set == 8'h00 &&  // [RULE_01]
        fast_shutdown_fault_ff == 8'h00) |=> state_ff == ST_RUN) else $error("run ended without fault");
    a_only_fault_stop: assert property ((state_ff == ST_RUN && !rf_off_cmd &&                // [RULE_02]
        fast_shutdown_fault_ff == 8'h00) |=> state_ff == ST_RUN) else $error("run left without cause");
    a_hb_loss_off: assert property (hb_lost |=> s_all_off) else $error("outputs on after heartbeat loss");  // [RULE_03]
    a_trip_all_off: assert property ((fast_shutdown_fault_ff != 8'h00) |=> s_all_off)        // [RULE_04]
        else $error("outputs on while fault latched");
    a_gain_range: assert property (gain_ff <= GAIN_MAX_DB) else $error("gain above limit");  // [RULE_07]
    a_grad_range: assert property (grad_ff <= GRAD_MAX) else $error("gradient above limit"); // [RULE_08]
    a_drive_helium: assert property (!helium_plant_ok_i |=> rf_drive_o == 8'h00)             // [RULE_13]
        else $error("drive without helium permissive");
    a_freeze_trig: assert property (s_trig_edge |=> frozen_ff) else $error("trigger did not freeze");  // [RULE_15]
    a_tuner_warn: assert property ((tuner_cnt_ff > TUNER_WARN) |=> tuner_warn_o)              // [RULE_18]
        else $error("tuner overrun not flagged");
    a_helium_trip: assert property ((state_ff == ST_RUN && !helium_plant_ok_i) |=>           // [RULE_19]
        fast_shutdown_fault_ff[FLT_HELIUM] ##1 state_ff == ST_TRIP) else $error("helium loss did not trip");
    a_helium_idle: assert property ((state_ff != ST_RUN && !fast_shutdown_fault_ff[FLT_HELIUM]) |=>  // [RULE_19]
        !fast_shutdown_fault_ff[FLT_HELIUM]) else $error("helium fault raised while off");
    a_fwd_unmasked: assert property (((raw_fwd != 8'h00) && !ctrl_ff[CTL_MASK_TUNE]) |=>    // [RULE_20]
        fast_shutdown_fault_ff[FLT_FWD_HIGH]) else $error("forward power fault missed");
    a_heat_masked: assert property ((ctrl_ff[CTL_MASK_HICUR] && !fast_shutdown_fault_ff[FLT_HEAT]) |=>  // [RULE_21]
        !fast_shutdown_fault_ff[FLT_HEAT]) else $error("masked heating fault raised");
    a_fault_latch: assert property (1'b1 |=> (fast_shutdown_fault_ff & $past(flt_keep)) == $past(flt_keep))  // [RULE_24]
        else $error("fault dropped without clear");
endmodule

//--- rack_model.sv
// amplifier rack and high-voltage supply model facing the permit outputs
`timescale 1ns/10ps
module rack_model (
    input  wire logic [7:0] amp_permit_i,
    input  wire logic [7:0] hv_permit_i,
    input  wire logic [7:0] drive_i,
    output logic      [7:0] fwd_power_o,
    output logic            hv_on_o
);
    assign hv_on_o = |hv_permit_i;
    // preamp unpowered without its permit, so no forward power
    assign fwd_power_o = hv_on_o ? (drive_i & amp_permit_i) : 8'h00;
endmodule

//--- test_rf_interlock_permit_supervisor.sv
// self-checking bench for the rf interlock permit supervisor
`timescale 1ns/10ps
module test_rf_interlock_permit_supervisor import rfsup_pkg::*; ;
    logic        clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, ack_o, hb = 0, hb_run = 0, he = 1;
    logic        trig = 0, step = 0, hot = 0, aloop, ploop, tauto, twarn, tuwarn, rpt, frz, hv_on;
    logic [7:0]  adr_i = 8'h00, quench = 8'h00, zero8 = 8'h00, fin = 8'h00, amp, hvp, drv, fwd;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic [3:0]  sel_i = 4'h0;
    logic [6:0]  gain, g;
    logic [14:0] grad;
    logic [31:0] exp_q[$];
    int          err_total = 0, comparisons = 0, cyc_n = 0, rpt_at = 0, rpt_gap = 0;
    rf_interlock_permit_supervisor #(.MS_CYC(10)) rf_interlock_permit_supervisor_i (.clk_i(clk_i), .rst_i(rst_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
        .ack_o(ack_o), .heartbeat_i(hb), .helium_plant_ok_i(he), .fwd_over_i(fin), .grad_under_i(zero8),
        .window_arc_i(zero8), .window_heat_i(fin), .quench_i(quench), .fwd_present_i(fwd), .air_hot_i(hot),
        .user_trig_i(trig), .tuner_step_i(step), .amp_permit_o(amp), .cathode_hv_supply_permit_o(hvp),
        .rf_drive_o(drv), .loop_gain_db_o(gain), .grad_set_o(grad), .amp_loop_closed_o(aloop),
        .phase_loop_closed_o(ploop), .tune_auto_o(tauto), .thermal_warn_o(twarn), .tuner_warn_o(tuwarn),
        .report_o(rpt), .hist_frozen_o(frz));
    rack_model rack_model_i (.amp_permit_i(amp), .hv_permit_i(hvp), .drive_i(drv), .fwd_power_o(fwd),
        .hv_on_o(hv_on));
    always #20 clk_i = ~clk_i;
    task automatic test_done;
        $display("checks %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(string n, logic [31:0] seen, logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, expv, seen);
        end
    endtask
    task automatic tick(int n = 2);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic cycle; a read notes its expected word for the watcher
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] e);
        @(posedge clk_i);
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hf;
        if (!w) exp_q.push_back(e);
        do @(posedge clk_i); while (ack_o !== 1'b1);
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
    endtask
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (hb_run) hb <= ~hb;
        if (rpt === 1'b1) begin rpt_gap <= cyc_n - rpt_at; rpt_at <= cyc_n; end
        if (ack_o === 1'b1 && we_i === 1'b0 && cyc_i === 1'b1) check("read", dat_o, exp_q.pop_front());
        if (cyc_n > 20000) begin err_total++; test_done; end
    end
    initial begin
        void'($urandom(32'h34064d1f));
        tick(20);
        rst_i <= 0; hb_run <= 1;
        tick(1); check("drive", drv, 8'h00);
        bus(0, REG_REPORT, 0, {28'h0, RATE_RST});
        bus(0, REG_HIST, 0, {28'h0, HIST_RST});
        bus(1, REG_GAIN, 32'hff, 0); bus(0, REG_GAIN, 0, {25'h0, GAIN_MAX_DB});
        g = 7'($urandom_range(100)); bus(1, REG_GAIN, {25'h0, g}, 0); tick(); check("gain", gain, g);
        bus(1, REG_GRAD, 32'h7fff, 0); tick(); check("grad", grad, GRAD_MAX);
        bus(1, REG_REPORT, 32'h0, 0); bus(0, REG_REPORT, 0, {28'h0, RATE_MIN});
        bus(1, REG_CTRL, 32'h1c, 0); tick(); check("loops", {aloop, ploop, tauto}, 3'b111);
        bus(1, REG_PERMIT, 32'hffff, 0); bus(1, REG_BYPASS, 32'h1, 0); bus(1, REG_CTRL, 32'h1d, 0); tick(3);
        check("drive", drv, 8'hfe);
        check("permits", {amp, hvp}, 16'hfefe); check("hv on", hv_on, 1'b1);
        bus(0, 8'hfc, 0, 0); hot <= 1; tick(3);
        check("warn", {twarn, drv}, 9'h1fe);
        repeat (3) begin step <= 1; tick(1); step <= 0; tick(1); end
        bus(0, REG_TUNER, 0, 32'h3); check("tuner", tuwarn, 1'b0);
        quench <= 8'h04; tick(3); check("trip", {amp, hvp, drv}, 24'h0);
        quench <= 8'h00; tick(3); check("held", {drv, frz}, 9'h001);
        bus(0, REG_FAULT, 0, 32'h20); bus(1, REG_FAULT, 32'hff, 0); bus(1, REG_CTRL, 32'h1d, 0); tick(3);
        check("restart", drv, 8'hfe);
        he <= 0; tick(3); check("helium", drv, 8'h00);
        bus(0, REG_FAULT, 0, 32'h01); bus(1, REG_FAULT, 32'hff, 0); he <= 1;
        // tune and high-current masks hold back forward power and heating faults
        bus(1, REG_REPORT, 32'ha, 0); bus(1, REG_CTRL, 32'h7c, 0); fin <= 8'h01 << $urandom_range(7, 1); tick(3);
        bus(0, REG_FAULT, 0, 0); bus(1, REG_CTRL, 32'h1c, 0); tick(); bus(0, REG_FAULT, 0, 32'h12);
        fin <= 8'h00; bus(1, REG_FAULT, 32'hff, 0); bus(1, REG_HIST, 32'h10a, 0);
        bus(0, REG_HIST, 0, {28'h0, HIST_MAX}); trig <= 1; tick(); check("trigger", frz, 1'b1);
        trig <= 0; bus(1, REG_CTRL, 32'h1d, 0); tick(3); hb_run <= 0; tick(2100);
        check("heartbeat", {amp, hvp, drv}, 24'h0);
        // 10 Hz is 100 ms, at 10 cycles per ms
        check("report gap", rpt_gap, 100 * 10);
        test_done;
    end
endmodule
